/* File: hdl/pcr_pkg.sv */
package pcr_pkg;

  // ****************************************************************
  // Command codes.
  // ****************************************************************
  localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7B;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7C;
  localparam logic [7:0] CMD_TEMPERATURE_STATUS = 8'h7D;
  localparam logic [7:0] CMD_COMM_LOGIC_STATUS = 8'h7E;
  localparam logic [7:0] CMD_INPUT_VOLTAGE_READING = 8'h88;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READING = 8'h8B;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_READING = 8'h8C;
  localparam logic [7:0] CMD_TEMPERATURE_READING = 8'h8D;
  localparam logic [7:0] CMD_MODULE_TYPE_PROTECT = 8'hD0;
  localparam logic [7:0] CMD_VOUT_READBACK_GAIN = 8'hD1;
  localparam logic [7:0] CMD_VOUT_READBACK_OFFSET = 8'hD2;
  localparam logic [7:0] CMD_VIN_READBACK_GAIN = 8'hD3;
  localparam logic [7:0] CMD_VIN_READBACK_OFFSET = 8'hD4;
  localparam logic [7:0] CMD_IOUT_READBACK_GAIN = 8'hD6;
  localparam logic [7:0] CMD_IOUT_READBACK_OFFSET = 8'hD7;
  localparam logic [7:0] CMD_FIRMWARE_REVISION = 8'hDB;

  // ****************************************************************
  // Status bit positions and implemented-bit masks.
  // ****************************************************************
  localparam int BIT_OVERCURRENT_FAULT = 7;
  localparam int BIT_OVERCURRENT_WARNING = 5;
  localparam int BIT_INPUT_OVERVOLTAGE = 7;
  localparam int BIT_INPUT_UNDERVOLTAGE = 4;
  localparam int BIT_UNIT_OFF_LOW_INPUT = 3;
  localparam int BIT_OVERTEMPERATURE_FAULT = 7;
  localparam int BIT_OVERTEMPERATURE_WARNING = 6;
  localparam int BIT_INVALID_COMMAND = 7;
  localparam int BIT_INVALID_DATA = 6;
  localparam int BIT_PACKET_CHECK_ERROR = 5;
  localparam logic [7:0] MASK_OUTPUT_CURRENT_STATUS = 8'hA0;
  localparam logic [7:0] MASK_INPUT_STATUS = 8'h98;
  localparam logic [7:0] MASK_TEMPERATURE_STATUS = 8'hC0;
  localparam logic [7:0] MASK_COMM_LOGIC_STATUS = 8'hE0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ****************************************************************
  // Module type word fields.
  // ****************************************************************
  localparam int NAME_MSB = 7;
  localparam int NAME_LSB = 2;
  localparam int PROTECT_BIT = 1;
  localparam logic PROTECT_RESET = 1'b1;
  localparam logic [7:0] TYPE_HIGH_BYTE = 8'h00;
  localparam logic TYPE_RESERVED_BIT = 1'b0;

  // ****************************************************************
  // Calibration limits, defaults and slots.
  // ****************************************************************
  localparam logic [15:0] GAIN_MIN = 16'h1999;
  localparam logic [15:0] GAIN_MAX = 16'h2666;
  localparam logic [15:0] GAIN_DEFAULT = 16'h2000;
  localparam logic [15:0] OFFSET_DEFAULT = 16'h0000;
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam logic [4:0] VOUT_OFFSET_EXP = 5'h14;
  localparam logic [4:0] VIN_OFFSET_EXP = 5'h1D;
  localparam logic [4:0] IOUT_OFFSET_EXP = 5'h1C;
  localparam int CAL_SLOTS = 6;
  localparam logic [2:0] SLOT_VOUT_GAIN = 3'h0;
  localparam logic [2:0] SLOT_VOUT_OFFSET = 3'h1;
  localparam logic [2:0] SLOT_VIN_GAIN = 3'h2;
  localparam logic [2:0] SLOT_VIN_OFFSET = 3'h3;
  localparam logic [2:0] SLOT_IOUT_GAIN = 3'h4;
  localparam logic [2:0] SLOT_IOUT_OFFSET = 3'h5;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } pcr_request_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [15:0] rdata;
  } pcr_response_t;

  typedef struct packed {
    logic overcurrent_fault;
    logic overcurrent_warning;
    logic input_overvoltage;
    logic input_undervoltage;
    logic unit_off_low_input;
    logic overtemperature_fault;
    logic overtemperature_warning;
    logic packet_check_error;
  } pcr_events_t;

  typedef struct packed {
    logic [15:0] input_voltage;
    logic [15:0] output_voltage;
    logic [15:0] output_current;
    logic [15:0] temperature;
  } pcr_telemetry_t;

endpackage : pcr_pkg

/* File: hdl/pcr_status_byte.sv */
`timescale 1ns/1ns
`default_nettype none
module pcr_status_byte #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_set,
  input wire logic [7:0] i_clear,
  output logic [7:0] o_value
);
  import pcr_pkg::*;

  // ****************************************************************
  // Sticky flags; a set in the clearing cycle wins.
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_value <= STATUS_RESET;
    end else begin
      o_value <= ((o_value & ~i_clear) | i_set) & MASK;
    end
  end
endmodule : pcr_status_byte
`default_nettype wire

/* File: hdl/pcr_cal_store.sv */
`timescale 1ns/1ns
`default_nettype none
module pcr_cal_store #(
  parameter int DEPTH = 6,
  parameter logic [15:0] IOUT_GAIN_DEFAULT = 16'h2000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [15:0] i_wdata,
  input wire logic [2:0] i_raddr,
  output logic [15:0] o_rdata
);
  import pcr_pkg::*;

  logic [15:0] mem [DEPTH];

  // ****************************************************************
  // Factory values restored at reset.
  // ****************************************************************
  function automatic logic [15:0] default_of(input int idx);
    if (idx == int'(SLOT_VOUT_GAIN) || idx == int'(SLOT_VIN_GAIN)) begin
      return GAIN_DEFAULT;
    end else if (idx == int'(SLOT_IOUT_GAIN)) begin
      return IOUT_GAIN_DEFAULT;
    end else begin
      return OFFSET_DEFAULT;
    end
  endfunction : default_of

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= default_of(i);
      end
    end else if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= OFFSET_DEFAULT;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : pcr_cal_store
`default_nettype wire

/* File: hdl/pcr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module pcr_regs #(
  parameter logic [5:0] NAME_CODE = 6'h2A, // Arbitrary value.
  parameter logic [7:0] FIRMWARE_REVISION = 8'h10, // Arbitrary value.
  parameter logic [15:0] IOUT_GAIN_DEFAULT = 16'h2000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire pcr_pkg::pcr_request_t i_req,
  input wire pcr_pkg::pcr_events_t i_events,
  input wire pcr_pkg::pcr_telemetry_t i_telemetry,
  output pcr_pkg::pcr_response_t o_rsp,
  output logic o_write_protect
);
  import pcr_pkg::*;

  // ****************************************************************
  // Command classes.
  // ****************************************************************
  typedef enum logic [3:0] {
    KIND_OUTPUT_CURRENT_STATUS,
    KIND_INPUT_STATUS,
    KIND_TEMPERATURE_STATUS,
    KIND_COMM_LOGIC_STATUS,
    KIND_READING,
    KIND_MODULE_TYPE,
    KIND_CALIBRATION,
    KIND_FIRMWARE,
    KIND_UNKNOWN
  } pcr_kind_t;

  // ****************************************************************
  // Decoding helpers.
  // ****************************************************************
  function automatic pcr_kind_t kind_of(input logic [7:0] code);
    if (code == CMD_OUTPUT_CURRENT_STATUS) begin
      return KIND_OUTPUT_CURRENT_STATUS;
    end else if (code == CMD_INPUT_STATUS) begin
      return KIND_INPUT_STATUS;
    end else if (code == CMD_TEMPERATURE_STATUS) begin
      return KIND_TEMPERATURE_STATUS;
    end else if (code == CMD_COMM_LOGIC_STATUS) begin
      return KIND_COMM_LOGIC_STATUS;
    end else if (code == CMD_INPUT_VOLTAGE_READING || code == CMD_OUTPUT_VOLTAGE_READING ||
                 code == CMD_OUTPUT_CURRENT_READING || code == CMD_TEMPERATURE_READING) begin
      return KIND_READING;
    end else if (code == CMD_MODULE_TYPE_PROTECT) begin
      return KIND_MODULE_TYPE;
    end else if (code == CMD_VOUT_READBACK_GAIN || code == CMD_VOUT_READBACK_OFFSET ||
                 code == CMD_VIN_READBACK_GAIN || code == CMD_VIN_READBACK_OFFSET ||
                 code == CMD_IOUT_READBACK_GAIN || code == CMD_IOUT_READBACK_OFFSET) begin
      return KIND_CALIBRATION;
    end else if (code == CMD_FIRMWARE_REVISION) begin
      return KIND_FIRMWARE;
    end else begin
      return KIND_UNKNOWN;
    end
  endfunction : kind_of

  function automatic logic [2:0] slot_of(input logic [7:0] code);
    if (code == CMD_VOUT_READBACK_GAIN) begin
      return SLOT_VOUT_GAIN;
    end else if (code == CMD_VOUT_READBACK_OFFSET) begin
      return SLOT_VOUT_OFFSET;
    end else if (code == CMD_VIN_READBACK_GAIN) begin
      return SLOT_VIN_GAIN;
    end else if (code == CMD_VIN_READBACK_OFFSET) begin
      return SLOT_VIN_OFFSET;
    end else if (code == CMD_IOUT_READBACK_GAIN) begin
      return SLOT_IOUT_GAIN;
    end else begin
      return SLOT_IOUT_OFFSET;
    end
  endfunction : slot_of

  function automatic logic value_legal(input logic [2:0] slot, input logic [15:0] data);
    if (slot == SLOT_VOUT_GAIN || slot == SLOT_VIN_GAIN || slot == SLOT_IOUT_GAIN) begin
      return (data >= GAIN_MIN) && (data <= GAIN_MAX);
    end else if (slot == SLOT_VOUT_OFFSET) begin
      return data[EXP_MSB:EXP_LSB] == VOUT_OFFSET_EXP;
    end else if (slot == SLOT_VIN_OFFSET) begin
      return data[EXP_MSB:EXP_LSB] == VIN_OFFSET_EXP;
    end else begin
      return data[EXP_MSB:EXP_LSB] == IOUT_OFFSET_EXP;
    end
  endfunction : value_legal

  function automatic logic [15:0] reading_of(input logic [7:0] code,
                                             input pcr_telemetry_t tel);
    if (code == CMD_INPUT_VOLTAGE_READING) begin
      return tel.input_voltage;
    end else if (code == CMD_OUTPUT_VOLTAGE_READING) begin
      return tel.output_voltage;
    end else if (code == CMD_OUTPUT_CURRENT_READING) begin
      return tel.output_current;
    end else begin
      return tel.temperature;
    end
  endfunction : reading_of

  // ****************************************************************
  // Request classification.
  // ****************************************************************
  pcr_kind_t kind;
  logic [2:0] slot;
  logic is_write;
  logic cal_reject;
  logic write_reject;
  logic cal_accept;
  logic [7:0] clear_byte;
  logic [5:0] name_code;
  logic write_protect_enable;

  always_comb begin
    kind = kind_of(i_req.code);
    slot = slot_of(i_req.code);
    is_write = i_req.valid && i_req.write;
    cal_reject = write_protect_enable || !value_legal(slot, i_req.wdata);
    cal_accept = is_write && (kind == KIND_CALIBRATION) && !cal_reject;
    write_reject = is_write && (((kind == KIND_CALIBRATION) && cal_reject) ||
                                (kind == KIND_READING) || (kind == KIND_FIRMWARE));
    clear_byte = i_req.wdata[7:0];
  end

  // ****************************************************************
  // Status bytes.
  // ****************************************************************
  logic [7:0] oc_set;
  logic [7:0] oc_clear;
  logic [7:0] in_set;
  logic [7:0] in_clear;
  logic [7:0] tp_set;
  logic [7:0] tp_clear;
  logic [7:0] cm_set;
  logic [7:0] cm_clear;
  logic [7:0] output_current_status;
  logic [7:0] input_status;
  logic [7:0] temperature_status;
  logic [7:0] comm_logic_status;

  always_comb begin
    oc_set = STATUS_RESET;
    oc_set[BIT_OVERCURRENT_FAULT] = i_events.overcurrent_fault;
    oc_set[BIT_OVERCURRENT_WARNING] = i_events.overcurrent_warning;
    in_set = STATUS_RESET;
    in_set[BIT_INPUT_OVERVOLTAGE] = i_events.input_overvoltage;
    in_set[BIT_INPUT_UNDERVOLTAGE] = i_events.input_undervoltage;
    in_set[BIT_UNIT_OFF_LOW_INPUT] = i_events.unit_off_low_input;
    tp_set = STATUS_RESET;
    tp_set[BIT_OVERTEMPERATURE_FAULT] = i_events.overtemperature_fault;
    tp_set[BIT_OVERTEMPERATURE_WARNING] = i_events.overtemperature_warning;
    cm_set = STATUS_RESET;
    cm_set[BIT_INVALID_COMMAND] = i_req.valid && (kind == KIND_UNKNOWN);
    cm_set[BIT_INVALID_DATA] = write_reject;
    cm_set[BIT_PACKET_CHECK_ERROR] = i_events.packet_check_error;
    oc_clear = (is_write && kind == KIND_OUTPUT_CURRENT_STATUS) ? clear_byte : STATUS_RESET;
    in_clear = (is_write && kind == KIND_INPUT_STATUS) ? clear_byte : STATUS_RESET;
    tp_clear = (is_write && kind == KIND_TEMPERATURE_STATUS) ? clear_byte : STATUS_RESET;
    cm_clear = (is_write && kind == KIND_COMM_LOGIC_STATUS) ? clear_byte : STATUS_RESET;
  end

  pcr_status_byte #(.MASK(MASK_OUTPUT_CURRENT_STATUS)) u_output_current_status (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_set(oc_set),
    .i_clear(oc_clear),
    .o_value(output_current_status)
  );

  pcr_status_byte #(.MASK(MASK_INPUT_STATUS)) u_input_status (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_set(in_set),
    .i_clear(in_clear),
    .o_value(input_status)
  );

  pcr_status_byte #(.MASK(MASK_TEMPERATURE_STATUS)) u_temperature_status (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_set(tp_set),
    .i_clear(tp_clear),
    .o_value(temperature_status)
  );

  pcr_status_byte #(.MASK(MASK_COMM_LOGIC_STATUS)) u_comm_logic_status (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_set(cm_set),
    .i_clear(cm_clear),
    .o_value(comm_logic_status)
  );

  // ****************************************************************
  // Module type word.
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      write_protect_enable <= PROTECT_RESET;
    end else if (is_write && kind == KIND_MODULE_TYPE) begin
      write_protect_enable <= i_req.wdata[PROTECT_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      name_code <= NAME_CODE;
    end else if (is_write && kind == KIND_MODULE_TYPE) begin
      name_code <= i_req.wdata[NAME_MSB:NAME_LSB];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_write_protect <= PROTECT_RESET;
    end else begin
      o_write_protect <= write_protect_enable;
    end
  end

  // ****************************************************************
  // Calibration store.
  // ****************************************************************
  logic [15:0] cal_rdata;

  pcr_cal_store #(.DEPTH(CAL_SLOTS), .IOUT_GAIN_DEFAULT(IOUT_GAIN_DEFAULT)) u_cal_store (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_we(cal_accept),
    .i_waddr(slot),
    .i_wdata(i_req.wdata),
    .i_raddr(slot),
    .o_rdata(cal_rdata)
  );

  // ****************************************************************
  // First stage: remember what was asked.
  // ****************************************************************
  logic p1_valid;
  logic p1_write;
  logic p1_ok;
  pcr_kind_t p1_kind;
  logic [15:0] p1_reading;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p1_valid <= 1'b0;
      p1_write <= 1'b0;
      p1_ok <= 1'b0;
      p1_kind <= KIND_UNKNOWN;
    end else begin
      p1_valid <= i_req.valid;
      p1_write <= i_req.write;
      p1_ok <= (kind != KIND_UNKNOWN) && !write_reject;
      p1_kind <= kind;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p1_reading <= OFFSET_DEFAULT;
    end else begin
      p1_reading <= reading_of(i_req.code, i_telemetry);
    end
  end

  // ****************************************************************
  // Second stage: answer.
  // ****************************************************************
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = OFFSET_DEFAULT;
    case (p1_kind)
      KIND_OUTPUT_CURRENT_STATUS: begin
        next_rdata = {TYPE_HIGH_BYTE, output_current_status};
      end
      KIND_INPUT_STATUS: begin
        next_rdata = {TYPE_HIGH_BYTE, input_status};
      end
      KIND_TEMPERATURE_STATUS: begin
        next_rdata = {TYPE_HIGH_BYTE, temperature_status};
      end
      KIND_COMM_LOGIC_STATUS: begin
        next_rdata = {TYPE_HIGH_BYTE, comm_logic_status};
      end
      KIND_READING: begin
        next_rdata = p1_reading;
      end
      KIND_MODULE_TYPE: begin
        next_rdata = {TYPE_HIGH_BYTE, name_code, write_protect_enable, TYPE_RESERVED_BIT};
      end
      KIND_CALIBRATION: begin
        next_rdata = cal_rdata;
      end
      KIND_FIRMWARE: begin
        next_rdata = {TYPE_HIGH_BYTE, FIRMWARE_REVISION};
      end
      default: begin
        next_rdata = OFFSET_DEFAULT;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= p1_valid;
      o_rsp.ok <= p1_valid && p1_ok;
      o_rsp.rdata <= (p1_valid && !p1_write) ? next_rdata : OFFSET_DEFAULT;
    end
  end
endmodule : pcr_regs
`default_nettype wire

/* File: verif/pcr_regs_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module pcr_regs_checker
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire pcr_request_t i_req,
  input wire pcr_events_t i_events,
  input wire pcr_telemetry_t i_telemetry,
  input wire pcr_response_t o_rsp,
  input wire logic o_write_protect
);
  // ****************************************************************
  // Request decode and properties.
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic rq;
  logic wr;
  logic rd;
  logic known;
  logic cal;
  logic [7:0] c;
  assign rq = i_req.valid;
  assign wr = rq & i_req.write;
  assign rd = rq & !i_req.write;
  assign c = i_req.code;
  assign known = c inside {[8'h7B:8'h7E], 8'h88, [8'h8B:8'h8D], [8'hD0:8'hD4], 8'hD6, 8'hD7, 8'hDB};
  assign cal = c inside {[8'hD1:8'hD4], 8'hD6, 8'hD7};
  property p_unknown; rq && !known |-> ##2 o_rsp.valid && !o_rsp.ok && o_rsp.rdata == 16'h0000;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code accepted");
  property p_quiet; o_rsp.valid |-> $past(rq, 2); endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_ok_idle; !o_rsp.valid |-> !o_rsp.ok; endproperty
  a_ok_idle: assert property (p_ok_idle) else $error("ok outside answer");
  property p_fw_ro; wr && c == CMD_FIRMWARE_REVISION |-> ##2 o_rsp.valid && !o_rsp.ok; endproperty
  a_fw_ro: assert property (p_fw_ro) else $error("revision write accepted");
  property p_gain;
    wr && c inside {8'hD1, 8'hD3, 8'hD6} && (i_req.wdata < GAIN_MIN || i_req.wdata > GAIN_MAX)
      |-> ##2 o_rsp.valid && !o_rsp.ok;
  endproperty
  a_gain: assert property (p_gain) else $error("gain out of range accepted");
  property p_lock;
    wr && cal && o_write_protect && !$past(wr && c == CMD_MODULE_TYPE_PROTECT)
      |-> ##2 o_rsp.valid && !o_rsp.ok;
  endproperty
  a_lock: assert property (p_lock) else $error("protected write accepted");
  property p_type; rd && c == CMD_MODULE_TYPE_PROTECT |-> ##2 o_rsp.rdata[15:8] == 8'h00 && !o_rsp.rdata[0];
  endproperty
  a_type: assert property (p_type) else $error("type reserved bits set");
  property p_iout; rd && c == CMD_OUTPUT_CURRENT_STATUS |-> ##2 (o_rsp.rdata & 16'hFF5F) == 16'h0000;
  endproperty
  a_iout: assert property (p_iout) else $error("current status extra bits");
  property p_input; rd && c == CMD_INPUT_STATUS |-> ##2 (o_rsp.rdata & 16'hFF67) == 16'h0000; endproperty
  a_input: assert property (p_input) else $error("input status extra bits");
  property p_temp; rd && c == CMD_TEMPERATURE_STATUS |-> ##2 (o_rsp.rdata & 16'hFF3F) == 16'h0000;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature status extra bits");
  property p_wp; $rose(i_reset_n) |-> o_write_protect; endproperty
  a_wp: assert property (p_wp) else $error("protect low after reset");
endmodule : pcr_regs_checker
bind pcr_regs pcr_regs_checker u_chk(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
  .i_events(i_events), .i_telemetry(i_telemetry), .o_rsp(o_rsp), .o_write_protect(o_write_protect));
`default_nettype wire

/* File: verif/pcr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pcr_host_model
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire pcr_response_t i_rsp,
  output var pcr_request_t o_req
);
  // ****************************************************************
  // Host transfers.
  // ****************************************************************
  initial o_req = '0;
  function automatic logic [15:0] offset_word(input logic [4:0] e, input logic [10:0] m);
    return {e, m};
  endfunction : offset_word
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
    output logic ok, output logic [15:0] r);
    ok = 1'bx;
    r = 16'hXXXX;
    @(posedge i_clk);
    o_req <= '{valid: 1'b1, write: w, code: c, wdata: d};
    @(posedge i_clk);
    o_req <= '0;
    for (int n = 0; n < 6; n++) begin
      @(posedge i_clk);
      if (i_rsp.valid === 1'b1) begin
        ok = i_rsp.ok;
        r = i_rsp.rdata;
        break;
      end
    end
  endtask : xfer
endmodule : pcr_host_model
`default_nettype wire

/* File: verif/test_pmbus_status_calibration_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module test_pmbus_status_calibration_regs;
  import pcr_pkg::*;
  // ****************************************************************
  // Bench.
  // ****************************************************************
  localparam logic [5:0] NAME = 6'h2A; // Arbitrary value.
  localparam logic [7:0] FW = 8'h10; // Arbitrary value.
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  pcr_request_t req;
  pcr_response_t rsp;
  pcr_events_t ev = '0;
  pcr_telemetry_t tel = {16'h1234, 16'h5678, 16'h9ABC, 16'h0DEF};
  logic wp;
  logic ok;
  logic [15:0] rd;
  int error_cnt = 0;
  int num_checks = 0;
  always #2 i_clk = ~i_clk;
  pcr_regs #(.NAME_CODE(NAME), .FIRMWARE_REVISION(FW), .IOUT_GAIN_DEFAULT(16'h2000)) dut(
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .i_events(ev), .i_telemetry(tel),
    .o_rsp(rsp), .o_write_protect(wp));
  pcr_host_model host(.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    host.xfer(1'b0, c, 16'h0000, ok, rd);
    chk_flag(ok, 1'b1);
    chk_data(rd, e);
  endtask : rd_chk
  task automatic wr_chk(input logic [7:0] c, input logic [15:0] d, input logic e);
    host.xfer(1'b1, c, d, ok, rd);
    chk_flag(ok, e);
  endtask : wr_chk
  task automatic t_defaults;
    rd_chk(CMD_VOUT_READBACK_GAIN, GAIN_DEFAULT);
    rd_chk(CMD_VIN_READBACK_GAIN, GAIN_DEFAULT);
    rd_chk(CMD_MODULE_TYPE_PROTECT, {8'h00, NAME, 2'b10});
    chk_flag(wp, 1'b1);
    rd_chk(CMD_FIRMWARE_REVISION, {8'h00, FW});
    for (int c = 8'h7B; c <= 8'h7E; c++) rd_chk(8'(c), 16'h0000);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_status;
    @(posedge i_clk);
    ev <= '1;
    @(posedge i_clk);
    ev <= '0;
    rd_chk(CMD_OUTPUT_CURRENT_STATUS, 16'h00A0);
    rd_chk(CMD_INPUT_STATUS, 16'h0098);
    rd_chk(CMD_TEMPERATURE_STATUS, 16'h00C0);
    rd_chk(CMD_COMM_LOGIC_STATUS, 16'h0020);
    for (int c = 8'h7B; c <= 8'h7E; c++) begin
      wr_chk(8'(c), 16'h00FF, 1'b1);
      rd_chk(8'(c), 16'h0000);
    end
    fork
      wr_chk(CMD_OUTPUT_CURRENT_STATUS, 16'h00FF, 1'b1);
      begin
        @(posedge i_clk);
        ev.overcurrent_fault <= 1'b1;
        @(posedge i_clk);
        ev <= '0;
      end
    join
    rd_chk(CMD_OUTPUT_CURRENT_STATUS, 16'h0080);
    wr_chk(CMD_OUTPUT_CURRENT_STATUS, 16'h00FF, 1'b1);
    rd_chk(CMD_OUTPUT_CURRENT_STATUS, 16'h0000);
    $display("status done");
  endtask : t_status
  task automatic t_reject;
    wr_chk(CMD_VOUT_READBACK_GAIN, 16'h2100, 1'b0);
    rd_chk(CMD_VOUT_READBACK_GAIN, GAIN_DEFAULT);
    rd_chk(CMD_COMM_LOGIC_STATUS, 16'h0040);
    wr_chk(CMD_COMM_LOGIC_STATUS, 16'h00FF, 1'b1);
    host.xfer(1'b0, 8'h00, 16'h0000, ok, rd);
    chk_flag(ok, 1'b0);
    rd_chk(CMD_COMM_LOGIC_STATUS, 16'h0080);
    wr_chk(CMD_COMM_LOGIC_STATUS, 16'h00FF, 1'b1);
    $display("reject done");
  endtask : t_reject
  task automatic t_cal;
    logic [7:0] g[3] = '{CMD_VOUT_READBACK_GAIN, CMD_VIN_READBACK_GAIN, CMD_IOUT_READBACK_GAIN};
    logic [7:0] o[3] = '{CMD_VOUT_READBACK_OFFSET, CMD_VIN_READBACK_OFFSET, CMD_IOUT_READBACK_OFFSET};
    logic [4:0] x[3] = '{5'h14, 5'h1D, 5'h1C};
    wr_chk(CMD_MODULE_TYPE_PROTECT, {8'h00, NAME, 2'b00}, 1'b1);
    chk_flag(wp, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr_chk(g[i], 16'h1998, 1'b0);
      wr_chk(g[i], 16'h2667, 1'b0);
      wr_chk(g[i], GAIN_MIN, 1'b1);
      rd_chk(g[i], GAIN_MIN);
      wr_chk(g[i], GAIN_MAX, 1'b1);
      rd_chk(g[i], GAIN_MAX);
      wr_chk(o[i], host.offset_word(x[i], 11'h155), 1'b1);
      wr_chk(o[i], host.offset_word(x[i] ^ 5'h01, 11'h0AA), 1'b0);
      rd_chk(o[i], {x[i], 11'h155});
    end
    rd_chk(CMD_COMM_LOGIC_STATUS, 16'h0040);
    wr_chk(CMD_COMM_LOGIC_STATUS, 16'h00FF, 1'b1);
    wr_chk(CMD_MODULE_TYPE_PROTECT, {8'h00, NAME, 2'b10}, 1'b1);
    wr_chk(CMD_IOUT_READBACK_OFFSET, {5'h1C, 11'h001}, 1'b0);
    rd_chk(CMD_IOUT_READBACK_OFFSET, {5'h1C, 11'h155});
    $display("calibration done");
  endtask : t_cal
  task automatic t_readonly;
    rd_chk(CMD_COMM_LOGIC_STATUS, 16'h0040);
    wr_chk(CMD_COMM_LOGIC_STATUS, 16'h00FF, 1'b1);
    wr_chk(CMD_FIRMWARE_REVISION, 16'h0055, 1'b0);
    rd_chk(CMD_FIRMWARE_REVISION, {8'h00, FW});
    rd_chk(CMD_COMM_LOGIC_STATUS, 16'h0040);
    wr_chk(CMD_COMM_LOGIC_STATUS, 16'h00FF, 1'b1);
    wr_chk(CMD_INPUT_VOLTAGE_READING, 16'h0001, 1'b0);
    rd_chk(CMD_INPUT_VOLTAGE_READING, tel.input_voltage);
    rd_chk(CMD_OUTPUT_VOLTAGE_READING, tel.output_voltage);
    rd_chk(CMD_OUTPUT_CURRENT_READING, tel.output_current);
    rd_chk(CMD_TEMPERATURE_READING, tel.temperature);
    rd_chk(CMD_COMM_LOGIC_STATUS, 16'h0040);
    $display("read-only done");
  endtask : t_readonly
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_defaults();
    t_status();
    t_reject();
    t_cal();
    t_readonly();
    end_of_test();
  end
  initial begin
    #80000;
    error_cnt++;
    end_of_test();
  end
endmodule : test_pmbus_status_calibration_regs
`default_nettype wire
